// *** design/link_cfg_defs.svh ***
// Summary of operation
// - The high-density, phase-adjust, adjust-count and adjust-direction fields always go out as zero.
// - Frames per multiframe, lanes, converters, resolution, total bits and samples per frame are sent as value minus one.
// - Frames per multiframe defaults to 3 and takes the programmed forced value while force-K is set.
// - Each lane reports its default identifier 1 to 8 unless its override enable selects the programmed identifier.
// - The resolution is set by the resolution control to 10, 12, 14 or 16 bits, default 12.
// - Total bits per sample follows the packing mode, serialization factor and lanes setting, default 12.
// - Samples per converter per frame is fixed at one.
// - The scrambler field reports the scrambler enable control, default off.
// - Each lane carries a computed 8-bit checksum unless its override enable selects the programmed checksum.
// - With version control enabled, version 000 reports 000 with subclass 000 and version 001 reports 001.
// - In version 001 with version control enabled, subclass settings 000, 001 and 010 are reported as given.
// - With version control disabled the settings are ignored and version 001 subclass 001 is reported.
// - After reset the configuration is 12-bit resolution and serialization, four converters per lane, normal packing.
`ifndef LINK_CFG_DEFS_SVH
`define LINK_CFG_DEFS_SVH

`define ADDR_CTRL         12'h000
`define ADDR_IDS          12'h004
`define ADDR_STATUS       12'h008
`define ADDR_LANE_BASE    12'h020
`define ADDR_LANE_LAST    12'h03c

`define CTRL_RESET        32'h0015_1800
`define CTRL_WMASK        32'h007f_ffff
`define IDS_WMASK         32'h0000_0fff
`define LANE_WMASK        32'h0001_ff9f

`define C_LINK_EN         0
`define C_PAR_DIS         1
`define C_VER_OVR         2
`define C_VER_LO          3
`define C_SUB_LO          6
`define C_SCR             9
`define C_FORCE_K         10
`define C_KVAL_LO         11
`define C_RES_LO          16
`define C_SER_LO          18
`define C_NAL_LO          20
`define C_SINGLE          22

`define IDS_BID_LO        8

`define LN_LID_EN         7
`define LN_CHK_LO         8
`define LN_CHK_EN         16
`define LN_CALC_LO        24

`define NUM_LANES         8
`define NUM_CONVERTERS    8'd16
`define K_DEFAULT         5'd3
`define SAMPLES_PER_FRAME 5'd1
`define BITS_BASE         5'd10
`define BITS_SINGLE       5'd16
`define BITS_PAD_LOW      5'd12
`define BITS_PAD_HIGH     5'd16
`define CODE_SER_14       2'd2
`define VER_A             3'b000
`define VER_B             3'b001
`define SUBCLASS_1        3'b001

`endif

// *** design/link_cfg_pkg.sv ***
package link_cfg_pkg;

    typedef enum logic [1:0] {
        ADC_PER_LANE_2 = 2'd0,
        ADC_PER_LANE_4 = 2'd1,
        ADC_PER_LANE_8 = 2'd2
    } adcs_per_lane_t;

    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_SETUP  = 2'b01,
        APB_ACCESS = 2'b11
    } apb_state_t;

    typedef struct packed {
        logic [7:0] did;
        logic [3:0] bid;
        logic [3:0] adjcnt;
        logic [4:0] lid;
        logic       phadj;
        logic       adjdir;
        logic       scr;
        logic [4:0] l;
        logic [7:0] f;
        logic [4:0] k;
        logic [7:0] m;
        logic [1:0] cs;
        logic [4:0] n;
        logic [2:0] subclassv;
        logic [4:0] np;
        logic [2:0] jesdv;
        logic [4:0] s;
        logic       hd;
        logic [4:0] cf;
        logic [7:0] res1;
        logic [7:0] res2;
        logic [7:0] fchk;
    } ila_fields_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : link_cfg_pkg

// *** design/link_cfg_params.sv ***
`timescale 1ns/1ns
`include "link_cfg_defs.svh"

module link_cfg_params
    import link_cfg_pkg::*;
(
    input  wire  logic                      pclk,
    input  wire  logic                      presetn,
    input  wire  apb_req_t                  apb_req,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    output logic                            serial_link_enable,
    output logic                            parallel_output_disable,
    output logic [`NUM_LANES-1:0]           lane_active,
    output ila_fields_t [`NUM_LANES-1:0]    lane_cfg
);

    // ==========================================================
    // Register file
    // ==========================================================
    logic [31:0]                 ctrl;
    logic [31:0]                 ids;
    logic [31:0]                 lane_reg      [`NUM_LANES];
    logic [31:0]                 next_ctrl;
    logic [31:0]                 next_ids;
    logic [31:0]                 next_lane_reg [`NUM_LANES];
    logic [31:0]                 next_prdata;
    logic                        next_pslverr;
    apb_state_t                  apb_state;
    apb_state_t                  next_apb_state;
    logic                        setup_phase;
    logic                        write_done;
    logic                        addr_is_lane;
    logic [2:0]                  lane_sel;
    logic [31:0]                 status_word;
    logic [7:0]                  calc_chk      [`NUM_LANES];
    logic                        hit_ctrl;
    logic                        hit_ids;
    logic                        hit_status;

    assign setup_phase  = apb_req.psel && !apb_req.penable;
    assign pready       = apb_req.psel && apb_req.penable;
    assign write_done   = pready && apb_req.pwrite && !pslverr;
    assign hit_ctrl     = apb_req.paddr == `ADDR_CTRL;
    assign hit_ids      = apb_req.paddr == `ADDR_IDS;
    assign hit_status   = apb_req.paddr == `ADDR_STATUS;
    assign addr_is_lane = (apb_req.paddr >= `ADDR_LANE_BASE) && (apb_req.paddr <= `ADDR_LANE_LAST)
                          && (apb_req.paddr[1:0] == 2'b00);
    assign lane_sel     = apb_req.paddr[4:2];

    // Read data and error are captured in the setup cycle so they stand as flops in the access cycle.
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        case (apb_state)
            APB_IDLE,
            APB_SETUP,
            APB_ACCESS: begin
                next_apb_state = apb_req.psel ? (apb_req.penable ? APB_ACCESS : APB_SETUP) : APB_IDLE;
            end
            default: begin
                next_apb_state = APB_IDLE;
            end
        endcase
        if (setup_phase) begin
            next_pslverr = 1'b0;
            next_prdata  = 32'h0000_0000;
            if (hit_ctrl) begin
                next_prdata = ctrl;
            end else if (hit_ids) begin
                next_prdata = ids;
            end else if (hit_status) begin
                next_prdata = status_word;
            end else if (addr_is_lane) begin
                next_prdata = lane_reg[lane_sel];
                next_prdata[31:`LN_CALC_LO] = calc_chk[lane_sel];
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state <= APB_IDLE;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
        end else begin
            apb_state <= next_apb_state;
            prdata    <= next_prdata;
            pslverr   <= next_pslverr;
        end
    end

    // A write lands at the edge that ends an access cycle without error.
    always_comb begin
        next_ctrl = ctrl;
        next_ids  = ids;
        for (int i = 0; i < `NUM_LANES; i++) begin
            next_lane_reg[i] = lane_reg[i];
        end
        if (write_done) begin
            if (hit_ctrl) begin
                next_ctrl = apb_req.pwdata & `CTRL_WMASK;
            end else if (hit_ids) begin
                next_ids = apb_req.pwdata & `IDS_WMASK;
            end else if (addr_is_lane) begin
                next_lane_reg[lane_sel] = apb_req.pwdata & `LANE_WMASK;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CTRL_RESET;
            ids  <= 32'h0000_0000;
            for (int i = 0; i < `NUM_LANES; i++) begin
                lane_reg[i] <= 32'h0000_0000;
            end
        end else begin
            ctrl <= next_ctrl;
            ids  <= next_ids;
            for (int i = 0; i < `NUM_LANES; i++) begin
                lane_reg[i] <= next_lane_reg[i];
            end
        end
    end

    // ==========================================================
    // Link parameter derivation
    // ==========================================================
    logic [1:0]     res_code;
    logic [1:0]     ser_code;
    adcs_per_lane_t nal;
    logic [4:0]     conv_bits;
    logic [4:0]     ser_bits;
    logic [4:0]     total_bits;
    logic [4:0]     num_lanes;
    logic [7:0]     octets;
    logic [4:0]     k_val;
    logic [2:0]     ver_field;
    logic [2:0]     sub_field;
    logic [7:0]     adc_count;

    assign res_code = ctrl[`C_RES_LO+1:`C_RES_LO];
    assign ser_code = ctrl[`C_SER_LO+1:`C_SER_LO];
    assign nal      = adcs_per_lane_t'(ctrl[`C_NAL_LO+1:`C_NAL_LO]);

    always_comb begin
        conv_bits = `BITS_BASE + {2'b00, res_code, 1'b0};
        ser_bits  = `BITS_BASE + {2'b00, ser_code, 1'b0};
        case (nal)
            ADC_PER_LANE_2: begin
                adc_count  = 8'd2;
                num_lanes  = 5'd8;
                total_bits = (ser_code < `CODE_SER_14) ? `BITS_PAD_LOW : `BITS_PAD_HIGH;
            end
            ADC_PER_LANE_8: begin
                adc_count  = 8'd8;
                num_lanes  = 5'd2;
                total_bits = ser_bits;
            end
            default: begin
                adc_count  = 8'd4;
                num_lanes  = 5'd4;
                total_bits = ser_bits;
            end
        endcase
        if (ctrl[`C_SINGLE]) begin
            total_bits = `BITS_SINGLE;
        end
        // Octets per frame is converters per lane times total bits over eight.
        octets = 8'((16'(adc_count) * 16'(total_bits)) >> 3);
        k_val  = ctrl[`C_FORCE_K] ? ctrl[`C_KVAL_LO+4:`C_KVAL_LO] : `K_DEFAULT;
    end

    // ==========================================================
    // Version and subclass
    // ==========================================================
    always_comb begin
        ver_field = `VER_B;
        sub_field = `SUBCLASS_1;
        if (ctrl[`C_VER_OVR]) begin
            case (ctrl[`C_VER_LO+2:`C_VER_LO])
                `VER_A: begin
                    ver_field = `VER_A;
                    sub_field = `VER_A;
                end
                default: begin
                    ver_field = ctrl[`C_VER_LO+2:`C_VER_LO];
                    sub_field = ctrl[`C_SUB_LO+2:`C_SUB_LO];
                end
            endcase
        end
    end

    assign status_word = {1'b0, sub_field, 1'b0, ver_field, 3'b000, k_val - 5'd1,
                          3'b000, total_bits - 5'd1, octets - 8'd1};

    // ==========================================================
    // Checksum
    // ==========================================================
    function automatic logic [7:0] field_sum(input ila_fields_t v);
        logic [7:0] acc;
        acc = v.did;
        acc = acc + 8'(v.bid);
        acc = acc + 8'(v.adjcnt);
        acc = acc + 8'(v.lid);
        acc = acc + 8'(v.phadj);
        acc = acc + 8'(v.adjdir);
        acc = acc + 8'(v.scr);
        acc = acc + 8'(v.l);
        acc = acc + v.f;
        acc = acc + 8'(v.k);
        acc = acc + v.m;
        acc = acc + 8'(v.cs);
        acc = acc + 8'(v.n);
        acc = acc + 8'(v.subclassv);
        acc = acc + 8'(v.np);
        acc = acc + 8'(v.jesdv);
        acc = acc + 8'(v.s);
        acc = acc + 8'(v.hd);
        acc = acc + 8'(v.cf);
        return acc;
    endfunction : field_sum

    // ==========================================================
    // Per-lane fields and checksum
    // ==========================================================
    ila_fields_t [`NUM_LANES-1:0] next_lane_cfg;
    logic        [`NUM_LANES-1:0] next_lane_active;

    genvar g;
    generate
        for (g = 0; g < `NUM_LANES; g++) begin : g_lane
            ila_fields_t f;
            logic [7:0]  sum;
            always_comb begin
                f           = '0;
                f.adjcnt    = '0;
                f.phadj     = 1'b0;
                f.adjdir    = 1'b0;
                f.hd        = 1'b0;
                f.cs        = '0;
                f.cf        = '0;
                f.res1      = '0;
                f.res2      = '0;
                f.did       = ids[7:0];
                f.bid       = ids[`IDS_BID_LO+3:`IDS_BID_LO];
                f.lid       = lane_reg[g][`LN_LID_EN] ? lane_reg[g][4:0] : 5'(g + 1);
                f.scr       = ctrl[`C_SCR];
                f.l         = num_lanes - 5'd1;
                f.f         = octets - 8'd1;
                f.k         = k_val - 5'd1;
                f.m         = `NUM_CONVERTERS - 8'd1;
                f.n         = conv_bits - 5'd1;
                f.np        = total_bits - 5'd1;
                f.s         = `SAMPLES_PER_FRAME - 5'd1;
                f.subclassv = sub_field;
                f.jesdv     = ver_field;
                sum = field_sum(f);
                f.fchk = lane_reg[g][`LN_CHK_EN] ? lane_reg[g][`LN_CHK_LO+7:`LN_CHK_LO] : sum;
                next_lane_cfg[g] = f;
            end
            assign calc_chk[g] = sum;
            // Lanes beyond the count in use stay idle: 8 lanes all, 4 every other, 2 every fourth.
            // The spare code falls to the default branch and runs as four converters per lane.
            always_comb begin
                case (nal)
                    ADC_PER_LANE_2: begin
                        next_lane_active[g] = 1'b1;
                    end
                    ADC_PER_LANE_8: begin
                        next_lane_active[g] = ((g % 4) == 0);
                    end
                    default: begin
                        next_lane_active[g] = ((g % 2) == 0);
                    end
                endcase
            end
        end
    endgenerate

    // ==========================================================
    // Output registers
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_cfg                <= '0;
            lane_active             <= '0;
            serial_link_enable      <= 1'b0;
            parallel_output_disable <= 1'b0;
        end else begin
            lane_cfg                <= next_lane_cfg;
            lane_active             <= next_lane_active;
            serial_link_enable      <= ctrl[`C_LINK_EN];
            parallel_output_disable <= ctrl[`C_PAR_DIS];
        end
    end

endmodule : link_cfg_params

// *** tb/link_rx_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Receiver model that verifies the lane configuration fields
module link_rx_model
    import link_cfg_pkg::*;
(
    input  wire ila_fields_t fields,
    output logic [7:0]       calc_fchk,
    output logic             fixed_ok
);
    // The receiver sums every encoded field into calc_fchk and checks that the fixed fields are zero.
    always_comb begin
        calc_fchk = fields.did + fields.bid + fields.adjcnt + fields.adjdir + fields.phadj + fields.lid
                  + fields.scr + fields.l + fields.f + fields.k + fields.m + fields.cs + fields.n
                  + fields.subclassv + fields.np + fields.jesdv + fields.s + fields.hd + fields.cf;
        fixed_ok = fields.hd == 1'b0 && fields.phadj == 1'b0 && fields.adjcnt == 4'h0
                && fields.adjdir == 1'b0 && fields.s == 5'h00;
    end
endmodule : link_rx_model

// *** tb/link_cfg_checker.sv ***
`timescale 1ns/1ns
`include "link_cfg_defs.svh"
// ==========================================================
// Checker
module link_cfg_checker
    import link_cfg_pkg::*;
(
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire apb_req_t                     apb_req,
    input wire logic                         pready,
    input wire logic [31:0]                  prdata,
    input wire logic                         pslverr,
    input wire logic                         serial_link_enable,
    input wire logic                         parallel_output_disable,
    input wire logic [`NUM_LANES-1:0]        lane_active,
    input wire ila_fields_t [`NUM_LANES-1:0] lane_cfg
);
    logic [31:0] wdata;
    assign wdata = apb_req.pwdata;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ctrl_wr;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == `ADDR_CTRL;
    endsequence
    property p_pready; pready == (apb_req.psel && apb_req.penable); endproperty
    property p_unmapped; apb_req.psel && apb_req.penable && apb_req.paddr >= 12'h040 |-> pslverr; endproperty
    property p_fixed; |lane_active |-> !lane_cfg[0].hd && !lane_cfg[7].phadj && lane_cfg[3].adjcnt == 4'h0; endproperty
    property p_const; |lane_active |-> lane_cfg[0].s == 5'h00 && lane_cfg[5].m == 8'd15; endproperty
    property p_ver_off; s_ctrl_wr ##0 !wdata[`C_VER_OVR] |=> ##1 lane_cfg[0].jesdv == 3'b001
        && lane_cfg[0].subclassv == 3'b001; endproperty
    property p_ver_a; s_ctrl_wr ##0 wdata[`C_VER_OVR] && wdata[5:3] == 3'b000 |=> ##1
        lane_cfg[0].jesdv == 3'b000 && lane_cfg[0].subclassv == 3'b000; endproperty
    property p_ver_b; s_ctrl_wr ##0 wdata[`C_VER_OVR] && wdata[5:3] == 3'b001 |=> ##1
        lane_cfg[1].jesdv == 3'b001 && lane_cfg[1].subclassv == $past(wdata[8:6], 2); endproperty
    property p_scr; s_ctrl_wr |=> ##1 lane_cfg[2].scr == $past(wdata[`C_SCR], 2); endproperty
    property p_link; s_ctrl_wr |=> ##1 serial_link_enable == $past(wdata[0], 2)
        && parallel_output_disable == $past(wdata[1], 2); endproperty
    property p_force_k; s_ctrl_wr ##0 wdata[`C_FORCE_K] |=> ##1 lane_cfg[0].k == $past(wdata[15:11], 2) - 5'd1;
    endproperty
    property p_auto_k; s_ctrl_wr ##0 !wdata[`C_FORCE_K] |=> ##1 lane_cfg[4].k == 5'd2; endproperty
    a_pready: assert property (p_pready) else $error("pready does not follow the access phase");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access without slave error");
    a_fixed: assert property (p_fixed) else $error("unused field not zero");
    a_const: assert property (p_const) else $error("fixed sample or converter count wrong");
    a_ver_off: assert property (p_ver_off) else $error("default version or subclass wrong");
    a_ver_a: assert property (p_ver_a) else $error("legacy version fields wrong");
    a_ver_b: assert property (p_ver_b) else $error("subclass not reported as set");
    a_scr: assert property (p_scr) else $error("scrambler field wrong");
    a_link: assert property (p_link) else $error("link enable outputs wrong");
    a_force_k: assert property (p_force_k) else $error("forced frame count wrong");
    a_auto_k: assert property (p_auto_k) else $error("automatic frame count wrong");
endmodule : link_cfg_checker

bind link_cfg_params link_cfg_checker link_cfg_checker_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_link_enable(serial_link_enable),
    .parallel_output_disable(parallel_output_disable), .lane_active(lane_active), .lane_cfg(lane_cfg));

// *** tb/jesd_link_config_params_test.sv ***
`timescale 1ns/1ns
`include "link_cfg_defs.svh"
// ==========================================================
// Testbench
module jesd_link_config_params_test
    import link_cfg_pkg::*;
;
    logic                         pclk = 1'b0;
    logic                         presetn = 1'b0;
    apb_req_t                     apb_req = '0;
    logic                         pready, pslverr, serial_link_enable, parallel_output_disable, fixed_ok, err;
    logic [31:0]                  prdata, rd, ctrl, ids;
    logic [7:0]                   lane_active, calc_fchk;
    logic [2:0]                   g = 3'd0;
    logic [31:0]                  lanes [8];
    logic [6:0]                   vt [6] = '{7'h7e, 7'h01, 7'h11, 7'h03, 7'h13, 7'h23};
    logic [31:0]                  corner [3] = '{32'h0015_8400, 32'h0060_0000, 32'h0034_7a00};
    ila_fields_t [`NUM_LANES-1:0] lane_cfg;
    ila_fields_t                  exp_f;
    integer                       num_errors = 0, compares = 0, seed = 32'h0fd6;
    link_cfg_params link_cfg_params_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .serial_link_enable(serial_link_enable),
        .parallel_output_disable(parallel_output_disable), .lane_active(lane_active), .lane_cfg(lane_cfg));
    link_rx_model link_rx_model_inst (.fields(lane_cfg[g]), .calc_fchk(calc_fchk), .fixed_ok(fixed_ok));
    initial forever #25 pclk = ~pclk;
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
        #1;
    endtask : wr
    function automatic ila_fields_t exp_cfg(input logic [31:0] c, input logic [31:0] ids, input logic [31:0] ln,
                                            input logic [2:0] lane);
        ila_fields_t e;
        logic [4:0]  np, ser;
        logic [7:0]  cpl;
        e = '0;
        ser = 5'd10 + {2'b0, c[19:18], 1'b0};
        cpl = (c[21:20] == 2'd0) ? 8'd2 : (c[21:20] == 2'd2) ? 8'd8 : 8'd4;
        np = c[22] ? 5'd16 : (cpl != 8'd2) ? ser : (ser > 5'd12) ? 5'd16 : 5'd12;
        e.did = ids[7:0];
        e.bid = ids[11:8];
        e.lid = ln[7] ? ln[4:0] : {2'b0, lane} + 5'd1;
        e.scr = c[9];
        e.l = 5'(16 / cpl - 1);
        e.f = 8'(cpl * np / 8 - 1);
        e.k = (c[10] ? c[15:11] : 5'd3) - 5'd1;
        e.m = 8'd15;
        e.n = 5'd9 + {2'b0, c[17:16], 1'b0};
        e.np = np - 5'd1;
        e.jesdv = c[2] ? c[5:3] : 3'b001;
        e.subclassv = !c[2] ? 3'b001 : (c[5:3] == 3'b000) ? 3'b000 : c[8:6];
        e.fchk = ln[16] ? ln[15:8] : e.did + e.bid + e.lid + e.scr + e.l + e.f + e.k + e.m + e.n
               + e.subclassv + e.np + e.jesdv;
        return e;
    endfunction : exp_cfg
    task automatic cfg_check(input logic [31:0] c);
        for (int j = 0; j < 8; j++) begin
            check(lane_cfg[j], exp_cfg(c, ids, lanes[j], 3'(j)));
        end
        check(lane_active, (c[21:20] == 2'd0) ? 8'hff : (c[21:20] == 2'd2) ? 8'h11 : 8'h55);
        check({fixed_ok, lanes[g][16] ? calc_fchk : lane_cfg[g].fchk}, {1'b1, calc_fchk});
    endtask : cfg_check
    task automatic print_verdict;
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial begin
        #(50 * 20000);
        num_errors++;
        print_verdict;
    end
    initial begin
        foreach (lanes[j]) lanes[j] = 32'h0;
        ids = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        cfg_check(`CTRL_RESET);
        apb(1'b0, `ADDR_CTRL, 32'h0);
        check(rd, `CTRL_RESET);
        apb(1'b0, 12'h100, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        check(err, 1'b1);
        for (int i = 0; i < 6; i++) begin
            ctrl = `CTRL_RESET;
            ctrl[8:2] = vt[i];
            wr(`ADDR_CTRL, ctrl);
            cfg_check(ctrl);
        end
        for (int i = 0; i < 27; i++) begin
            ctrl = (i < 3) ? corner[i] : $random(seed) & `CTRL_WMASK & 32'hffff_fffa;
            ids = $random(seed) & `IDS_WMASK;
            g = 3'($random(seed));
            lanes[g] = $random(seed) & `LANE_WMASK;
            wr(`ADDR_IDS, ids);
            wr(`ADDR_LANE_BASE + {7'h0, g, 2'b0}, lanes[g]);
            wr(`ADDR_CTRL, ctrl);
            wr(`ADDR_CTRL, ctrl | 32'h1);
            check(serial_link_enable, 1'b1);
            cfg_check(ctrl);
            apb(1'b0, `ADDR_CTRL, 32'h0);
            check(rd, ctrl | 32'h1);
            exp_f = exp_cfg(ctrl, ids, lanes[g] & ~32'h0001_0000, g);
            apb(1'b0, `ADDR_STATUS, 32'h0);
            check(rd, {1'b0, exp_f.subclassv, 1'b0, exp_f.jesdv, 3'b000, exp_f.k, 3'b000, exp_f.np, exp_f.f});
            apb(1'b0, `ADDR_LANE_BASE + {7'h0, g, 2'b0}, 32'h0);
            check(rd, {exp_f.fchk, lanes[g][23:0]});
        end
        print_verdict;
    end
endmodule : jesd_link_config_params_test
